// *** rtl/mfd_decoder.sv ***
// Instruction format decoder with branch evaluation, behind AHB-Lite.
// Assumes single word transfers from one master; irq_req_pin is asynchronous.
// How it works
// - Single operand: bits 15-6 opcode, bit 15 byte, bits 5-0 destination.
// - Double operand: source bits 11-6, destination bits 5-0, split independently.
// - Double operand opcode is bits 14-12.
// - Bit 15 is byte select, except opcode 6: clear add, set subtract.
// - Add and subtract never take byte width.
// - Byte move to register mode sign-extends into the upper byte.
// - Byte move takes flags from the 8-bit result.
// - Branch: upper byte selects condition, lower byte is word offset.
// - Target is sign-extended offset shifted left once plus program counter.
// - Program counter is first stepped two bytes past the branch word.
// - Unconditional and single-flag branches on Z, N, V and C.
// - Signed compares: ge, lt, gt, le from the flags.
// - Unsigned compares: higher, lower or same, higher or same, lower.
// - Loop op decrements a register and branches while nonzero.
// - Call is 004 in bits 15-9, link bits 8-6, target bits 5-0.
// - Return is 00020 in bits 15-3, link register in bits 2-0.
// - Flag op: bits 15-5 opcode, bit 4 set or clear, bits 3-0 select.
// - External request goes to service routine; trap op to software routine.
// - Mode codes 0,2,4,6 are register, autoinc, autodec, index; odd deferred.
// - Four status flags N, Z, V, C, each true when one.
`timescale 1ns/1ns
module mfd_decoder
   import mfd_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Control transfer
   input  wire logic        irq_req_pin,
   output logic             isr_transfer,
   output logic             trap_transfer
);

   // Mode kind and deferred bit from a 3-bit mode
   function automatic logic [2:0] mode_info(input logic [2:0] m);
      mode_info = {m[2:1], m[0]};
   endfunction

   // Branch condition from opcode byte and flags
   function automatic logic cond_true(input logic [7:0] op, input logic [3:0] f);
      logic n;
      logic z;
      logic v;
      logic c;
      n = f[MFD_FN];
      z = f[MFD_FZ];
      v = f[MFD_FV];
      c = f[MFD_FC];
      unique case (op)
         MFD_B_ALW: cond_true = 1'b1;
         MFD_B_NE:  cond_true = !z;
         MFD_B_EQ:  cond_true = z;
         MFD_B_PL:  cond_true = !n;
         MFD_B_MI:  cond_true = n;
         MFD_B_VC:  cond_true = !v;
         MFD_B_VS:  cond_true = v;
         MFD_B_HIS: cond_true = !c;
         MFD_B_LO:  cond_true = c;
         MFD_B_GE:  cond_true = !(n ^ v);
         MFD_B_LT:  cond_true = n ^ v;
         MFD_B_GT:  cond_true = !(z | (n ^ v));
         MFD_B_LE:  cond_true = z | (n ^ v);
         MFD_B_HI:  cond_true = !(c | z);
         MFD_B_LOS: cond_true = c | z;
         default:   cond_true = 1'b0;
      endcase
   endfunction

   // Bus phase tracking
   logic        wr_pend_ff;
   logic        rd_pend_ff;
   logic [7:0]  addr_ff;
   logic [31:0] hrdata_ff;
   logic        hreadyout_ff;
   // Architectural state
   logic [15:0] instr_ff;
   logic [15:0] pc_ff;
   logic [3:0]  flags_ff;
   logic [15:0] operand_ff;
   logic [15:0] target_ff;
   logic [15:0] result_ff;
   logic [31:0] dec0_ff;
   logic [31:0] dec1_ff;
   // Synchroniser and transfer pulses
   logic        irq_meta_ff;
   logic        irq_sync_ff;
   logic        isr_ff;
   logic        trap_ff;

   logic        addr_ok;
   logic        exec;
   logic [15:0] w;
   mfd_fmt_t    fmt;
   logic [2:0]  op3;
   logic        byte_sel;
   logic        sub_sel;
   logic        taken;
   logic [15:0] pc_adv;
   logic [15:0] br_target;
   logic [15:0] loop_target;
   logic [15:0] decr_val;
   logic [15:0] nxt_pc;
   logic [3:0]  nxt_flags;
   logic [15:0] nxt_operand;
   logic [15:0] nxt_result;
   logic [2:0]  dst_info;
   logic [2:0]  src_info;

   assign addr_ok = hsel && htrans[1] && hready;
   assign exec    = wr_pend_ff && (addr_ff == MFD_OFF_INSTR);
   // Decode straight from the bus so results land in the write edge
   assign w       = hwdata[15:0];
   assign op3     = w[14:12];
   assign dst_info = mode_info(w[5:3]);
   assign src_info = mode_info(w[11:9]);

   // Format classification
   always_comb
   begin
      if (w[15:5] == MFD_CC_OP)
         fmt = MFD_FMT_CCODE;
      else if (w[15:3] == MFD_RET_OP)
         fmt = MFD_FMT_RETURN;
      else if ((!w[15] && w[14:11] == 4'h0 && w[10:8] != 3'h0)
               || (w[15:11] == 5'h10))
         fmt = MFD_FMT_BRANCH;
      else if (w[15:9] == MFD_CALL_OP)
         fmt = MFD_FMT_CALL;
      else if (w[15:9] == MFD_TRAP_OP)
         fmt = MFD_FMT_TRAP;
      else if (w[15:9] == MFD_LOOP_OP)
         fmt = MFD_FMT_LOOP;
      else if (op3 != MFD_OP3_NONE && op3 != MFD_OP3_EXT)
         fmt = MFD_FMT_DOUBLE;
      else
         fmt = MFD_FMT_SINGLE;
   end

   // Width and add/subtract selection
   always_comb
   begin
      sub_sel  = 1'b0;
      byte_sel = 1'b0;
      if (fmt == MFD_FMT_DOUBLE)
      begin
         if (op3 == MFD_ADDSUB)
            sub_sel = w[15];
         else
            byte_sel = w[15];
      end
      else if (fmt == MFD_FMT_SINGLE)
         byte_sel = w[15];
   end

   // Branch and loop targets
   assign pc_adv    = pc_ff + 16'h0002;
   assign br_target = pc_adv + {{7{w[7]}}, w[7:0], 1'b0};
   assign loop_target = pc_adv - {9'h000, w[5:0], 1'b0};
   assign decr_val  = operand_ff - 16'h0001;

   always_comb
   begin
      unique case (fmt)
         MFD_FMT_BRANCH: taken = cond_true(w[15:8], flags_ff);
         MFD_FMT_LOOP:   taken = (decr_val != 16'h0000);
         default:        taken = 1'b0;
      endcase
   end

   // Next program counter, flags, operand and result
   always_comb
   begin
      nxt_pc      = pc_adv;
      nxt_flags   = flags_ff;
      nxt_operand = operand_ff;
      nxt_result  = result_ff;
      if (fmt == MFD_FMT_BRANCH && taken)
         nxt_pc = br_target;
      if (fmt == MFD_FMT_LOOP)
      begin
         nxt_operand = decr_val;
         if (taken)
            nxt_pc = loop_target;
      end
      if (fmt == MFD_FMT_CCODE)
      begin
         // Select bits line up with the flag nibble
         if (w[4])
            nxt_flags = flags_ff | w[3:0];
         else
            nxt_flags = flags_ff & ~w[3:0];
      end
      if (fmt == MFD_FMT_DOUBLE && op3 == MFD_MOVE)
      begin
         nxt_flags[MFD_FV] = 1'b0;
         if (byte_sel)
         begin
            nxt_flags[MFD_FN] = operand_ff[7];
            nxt_flags[MFD_FZ] = (operand_ff[7:0] == 8'h00);
            if (w[5:3] == 3'h0)
               nxt_result = {{8{operand_ff[7]}}, operand_ff[7:0]};
            else
               nxt_result = {8'h00, operand_ff[7:0]};
         end
         else
         begin
            nxt_flags[MFD_FN] = operand_ff[15];
            nxt_flags[MFD_FZ] = (operand_ff == 16'h0000);
            nxt_result = operand_ff;
         end
      end
   end

   // Bus address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end
      else
      begin
         if (hready)
         begin
            wr_pend_ff <= addr_ok && hwrite;
            addr_ff    <= haddr;
         end
         // Reads take one wait so they see writes just completed
         rd_pend_ff <= hready && addr_ok && !hwrite;
      end
   end

   // Read data and ready
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff    <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
      end
      else
      begin
         hreadyout_ff <= !(hready && addr_ok && !hwrite);
         if (rd_pend_ff)
         begin
            unique case (addr_ff)
               MFD_OFF_INSTR:   hrdata_ff <= {16'h0000, instr_ff};
               MFD_OFF_PC:      hrdata_ff <= {16'h0000, pc_ff};
               MFD_OFF_FLAGS:   hrdata_ff <= {28'h0000000, flags_ff};
               MFD_OFF_OPERAND: hrdata_ff <= {16'h0000, operand_ff};
               MFD_OFF_DEC0:    hrdata_ff <= dec0_ff;
               MFD_OFF_DEC1:    hrdata_ff <= dec1_ff;
               MFD_OFF_TARGET:  hrdata_ff <= {16'h0000, target_ff};
               MFD_OFF_RESULT:  hrdata_ff <= {16'h0000, result_ff};
               default:         hrdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Program counter, flags and operand registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pc_ff      <= MFD_RST_WORD;
         flags_ff   <= MFD_RST_FLAGS;
         operand_ff <= MFD_RST_WORD;
         result_ff  <= MFD_RST_WORD;
      end
      else if (exec)
      begin
         pc_ff      <= nxt_pc;
         flags_ff   <= nxt_flags;
         operand_ff <= nxt_operand;
         result_ff  <= nxt_result;
      end
      else if (wr_pend_ff)
      begin
         if (addr_ff == MFD_OFF_PC)
            pc_ff <= hwdata[15:0];
         if (addr_ff == MFD_OFF_FLAGS)
            flags_ff <= hwdata[3:0];
         if (addr_ff == MFD_OFF_OPERAND)
            operand_ff <= hwdata[15:0];
      end
   end

   // Captured instruction and decoded fields
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         instr_ff  <= MFD_RST_WORD;
         target_ff <= MFD_RST_WORD;
         dec0_ff   <= 32'h0000_0000;
         dec1_ff   <= 32'h0000_0000;
      end
      else if (exec)
      begin
         instr_ff  <= w;
         target_ff <= (fmt == MFD_FMT_LOOP) ? loop_target : br_target;
         dec0_ff   <= {2'h0, w[15:8], op3, w[15:6], irq_sync_ff && exec,
                       fmt == MFD_FMT_TRAP, taken, sub_sel, byte_sel, fmt};
         dec1_ff   <= {3'h0, src_info, dst_info,
                       w[4], w[3:0],
                       w[2:0],
                       w[8:6],
                       w[11:9], w[8:6],
                       w[5:3], w[2:0]};
      end
   end

   // Request synchroniser
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_meta_ff <= 1'b0;
         irq_sync_ff <= 1'b0;
      end
      else
      begin
         irq_meta_ff <= irq_req_pin;
         irq_sync_ff <= irq_meta_ff;
      end
   end

   // Control transfer pulses; request sampled at instruction boundary
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         isr_ff  <= 1'b0;
         trap_ff <= 1'b0;
      end
      else
      begin
         isr_ff  <= exec && irq_sync_ff;
         trap_ff <= exec && fmt == MFD_FMT_TRAP;
      end
   end

   assign hrdata        = hrdata_ff;
   assign hreadyout     = hreadyout_ff;
   assign hresp         = 1'b0;
   assign isr_transfer  = isr_ff;
   assign trap_transfer = trap_ff;

endmodule

// *** rtl/mfd_pkg.sv ***
// Constants shared by the instruction format decoder.
// Assumes a 32-bit AHB-Lite bus with word-aligned register access.
package mfd_pkg;
   // Register byte offsets
   localparam logic [7:0] MFD_OFF_INSTR   = 8'h00;
   localparam logic [7:0] MFD_OFF_PC      = 8'h04;
   localparam logic [7:0] MFD_OFF_FLAGS   = 8'h08;
   localparam logic [7:0] MFD_OFF_OPERAND = 8'h0c;
   localparam logic [7:0] MFD_OFF_DEC0    = 8'h10;
   localparam logic [7:0] MFD_OFF_DEC1    = 8'h14;
   localparam logic [7:0] MFD_OFF_TARGET  = 8'h18;
   localparam logic [7:0] MFD_OFF_RESULT  = 8'h1c;
   // Reset values
   localparam logic [15:0] MFD_RST_WORD  = 16'h0000;
   localparam logic [3:0]  MFD_RST_FLAGS = 4'h0;
   // Flag positions in the status nibble
   localparam int MFD_FN = 3;
   localparam int MFD_FZ = 2;
   localparam int MFD_FV = 1;
   localparam int MFD_FC = 0;
   // Opcode patterns
   localparam logic [10:0] MFD_CC_OP    = 11'h005;
   localparam logic [12:0] MFD_RET_OP   = 13'h0010;
   localparam logic [6:0]  MFD_CALL_OP  = 7'h04;
   localparam logic [6:0]  MFD_LOOP_OP  = 7'h3f;
   localparam logic [6:0]  MFD_TRAP_OP  = 7'h44;
   localparam logic [2:0]  MFD_ADDSUB   = 3'h6;
   localparam logic [2:0]  MFD_MOVE     = 3'h1;
   localparam logic [2:0]  MFD_OP3_NONE = 3'h0;
   localparam logic [2:0]  MFD_OP3_EXT  = 3'h7;
   // Branch opcode bytes
   localparam logic [7:0] MFD_B_ALW = 8'h01;
   localparam logic [7:0] MFD_B_NE  = 8'h02;
   localparam logic [7:0] MFD_B_EQ  = 8'h03;
   localparam logic [7:0] MFD_B_GE  = 8'h04;
   localparam logic [7:0] MFD_B_LT  = 8'h05;
   localparam logic [7:0] MFD_B_GT  = 8'h06;
   localparam logic [7:0] MFD_B_LE  = 8'h07;
   localparam logic [7:0] MFD_B_PL  = 8'h80;
   localparam logic [7:0] MFD_B_MI  = 8'h81;
   localparam logic [7:0] MFD_B_HI  = 8'h82;
   localparam logic [7:0] MFD_B_LOS = 8'h83;
   localparam logic [7:0] MFD_B_VC  = 8'h84;
   localparam logic [7:0] MFD_B_VS  = 8'h85;
   localparam logic [7:0] MFD_B_HIS = 8'h86;
   localparam logic [7:0] MFD_B_LO  = 8'h87;
   // Format classes, Gray along the usual order
   typedef enum logic [3:0] {
      MFD_FMT_SINGLE = 4'h0,
      MFD_FMT_DOUBLE = 4'h1,
      MFD_FMT_BRANCH = 4'h3,
      MFD_FMT_CALL   = 4'h2,
      MFD_FMT_RETURN = 4'h6,
      MFD_FMT_CCODE  = 4'h7,
      MFD_FMT_LOOP   = 4'h5,
      MFD_FMT_TRAP   = 4'h4
   } mfd_fmt_t;
endpackage

// *** tb/mfd_decoder_chk.sv ***
// Port-level timing checks for the instruction format decoder.
// Assumes hready is looped from hreadyout and one bus master.
`timescale 1ns/1ns
module mfd_decoder_chk
   import mfd_pkg::*;
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Control transfer
   input wire logic        irq_req_pin,
   input wire logic        isr_transfer,
   input wire logic        trap_transfer
);
   logic       take;
   logic       ins_ff;
   logic       ex_ff;
   logic       ex_trap_ff;
   logic       ex_irq_ff;
   logic [2:0] pin_ff;
   assign take = hsel & htrans[1] & hready;
   // Pin high for three edges, so any two-flop sync has it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ins_ff     <= 1'b0;
         ex_ff      <= 1'b0;
         ex_trap_ff <= 1'b0;
         ex_irq_ff  <= 1'b0;
         pin_ff     <= 3'h0;
      end
      else
      begin
         if (hready)
            ins_ff <= take & hwrite & (haddr == MFD_OFF_INSTR);
         ex_ff      <= ins_ff & hready;
         ex_trap_ff <= ins_ff & hready & (hwdata[15:9] == MFD_TRAP_OP);
         ex_irq_ff  <= ins_ff & hready & (&pin_ff);
         pin_ff     <= {pin_ff[1:0], irq_req_pin};
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   chk_read_wait: assert property (take & !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (take & hwrite |=> hreadyout)
      else $error("write inserted a wait");
   chk_wait_once: assert property (!hreadyout |=> hreadyout)
      else $error("wait longer than one cycle");
   chk_trap_cause: assert property (trap_transfer == ex_trap_ff)
      else $error("trap pulse without trap word");
   chk_trap_pulse: assert property (trap_transfer |=> !trap_transfer)
      else $error("trap pulse too long");
   chk_isr_cause: assert property (isr_transfer |-> ex_ff)
      else $error("service pulse without execute");
   chk_isr_taken: assert property (ex_irq_ff |-> isr_transfer)
      else $error("service request missed");
   chk_isr_pulse: assert property (isr_transfer |=> !isr_transfer)
      else $error("service pulse too long");
   cov_trap: cover property (trap_transfer);
   cov_isr: cover property (isr_transfer);
   cov_read: cover property (take & !hwrite);
endmodule
bind mfd_decoder mfd_decoder_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .irq_req_pin(irq_req_pin), .isr_transfer(isr_transfer), .trap_transfer(trap_transfer));

// *** tb/tb_top.sv ***
// Self-checking bench for the instruction format decoder.
// Assumes the decoder is the only slave, hready looped from hreadyout.
`timescale 1ns/1ns
module tb_top
   import mfd_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, irq_req_pin, hready;
   logic        hreadyout, hresp, isr_transfer, trap_transfer;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [7:0]  codes [15];
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   assign hready = hreadyout;
   mfd_decoder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_req_pin(irq_req_pin),
      .isr_transfer(isr_transfer), .trap_transfer(trap_transfer));
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Ceiling well above the roughly 6.3k cycles the run needs
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_mismatch = n_mismatch + 1;
         close_out();
      end
   end
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One single transfer; read data kept in rd
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(a, 1'b0, 32'h0);
      cmp(rd, exp, what);
   endtask
   task automatic exe(input logic [15:0] pc, input logic [3:0] f, input logic [15:0] op,
                      input logic [15:0] w);
      xfer(MFD_OFF_PC, 1'b1, {16'h0, pc});
      xfer(MFD_OFF_FLAGS, 1'b1, {28'h0, f});
      xfer(MFD_OFF_OPERAND, 1'b1, {16'h0, op});
      xfer(MFD_OFF_INSTR, 1'b1, {16'h0, w});
   endtask
   function automatic logic taken(input logic [7:0] c, input logic [3:0] f);
      logic n, z, v, k;
      {n, z, v, k} = f;
      case (c)
         MFD_B_ALW: return 1'b1;
         MFD_B_NE:  return !z;
         MFD_B_EQ:  return z;
         MFD_B_GE:  return n == v;
         MFD_B_LT:  return n ^ v;
         MFD_B_GT:  return !(z | (n ^ v));
         MFD_B_LE:  return z | (n ^ v);
         MFD_B_PL:  return !n;
         MFD_B_MI:  return n;
         MFD_B_HI:  return !(k | z);
         MFD_B_LOS: return k | z;
         MFD_B_VC:  return !v;
         MFD_B_VS:  return v;
         MFD_B_HIS: return !k;
         default:   return k;
      endcase
   endfunction
   // Every condition against every flag pattern; offsets ff and 00 included
   task automatic t_branch();
      logic [7:0]  off;
      logic [15:0] tgt;
      logic        t;
      for (int i = 0; i < 15; i++)
         for (int f = 0; f < 16; f++)
         begin
            off = {f[3:0], f[3:0]};
            tgt = 16'h1002 + {{7{off[7]}}, off, 1'b0};
            t = taken(codes[i], f[3:0]);
            exe(16'h1000, f[3:0], 16'h0, {codes[i], off});
            rchk(MFD_OFF_TARGET, {16'h0, tgt}, "target");
            rchk(MFD_OFF_PC, {16'h0, t ? tgt : 16'h1002}, "pc");
            xfer(MFD_OFF_DEC0, 1'b0, 32'h0);
            cmp({31'h0, rd[6]}, {31'h0, t}, "taken");
            cmp({24'h0, rd[29:22]}, {24'h0, codes[i]}, "bcode");
         end
   endtask
   task automatic t_double();
      logic [2:0] sm, dm, sr, dr, o;
      for (int b = 0; b < 2; b++)
         for (int k = 1; k < 7; k++)
         begin
            o = k[2:0];
            sm = o + b[2:0];
            dm = 3'h6 - o;
            sr = o;
            dr = 3'h7 - o;
            exe(16'h0, 4'h0, 16'h0, {b[0], o, sm, sr, dm, dr});
            xfer(MFD_OFF_DEC0, 1'b0, 32'h0);
            cmp({rd[21:19], rd[5:0]}, {o, b[0] & (o == 6), b[0] & (o != 6), 4'h1},
                "dbl dec0");
            xfer(MFD_OFF_DEC1, 1'b0, 32'h0);
            cmp({rd[28:23], rd[11:0]}, {sm, dm, sm, sr, dm, dr}, "dbl dec1");
         end
   endtask
   task automatic mv(input logic b, input logic [2:0] dm, input logic [15:0] op,
                     input logic [3:0] f0, input logic [15:0] res, input logic [3:0] f1);
      exe(16'h0, f0, op, {b, 3'h1, 6'h00, dm, 3'h2});
      rchk(MFD_OFF_RESULT, {16'h0, res}, "move");
      rchk(MFD_OFF_FLAGS, {28'h0, f1}, "move flags");
   endtask
   task automatic t_single();
      logic [15:0] w [2];
      w = '{16'h8a1f, 16'h0a3a};
      for (int i = 0; i < 2; i++)
      begin
         exe(16'h0, 4'h0, 16'h0, w[i]);
         xfer(MFD_OFF_DEC0, 1'b0, 32'h0);
         cmp({rd[18:9], rd[4:0]}, {w[i][15:6], w[i][15], 4'h0}, "single");
         xfer(MFD_OFF_DEC1, 1'b0, 32'h0);
         cmp({rd[25:23], rd[5:0]}, {w[i][5:3], w[i][5:0]}, "sdst");
      end
   endtask
   task automatic t_ctl();
      // Link and destination both the counter register, never the stack pointer
      exe(16'h0, 4'h0, 16'h0, 16'h09f7);
      xfer(MFD_OFF_DEC0, 1'b0, 32'h0);
      cmp({23'h0, rd[8:0]}, 32'h2, "call fmt");
      xfer(MFD_OFF_DEC1, 1'b0, 32'h0);
      cmp({rd[14:12], rd[5:0]}, {3'h7, 6'h37}, "call");
      // Return names the link used by the call above
      exe(16'h0, 4'h0, 16'h0, 16'h0087);
      xfer(MFD_OFF_DEC1, 1'b0, 32'h0);
      cmp({rd[17:15]}, 3'h7, "return");
      exe(16'h0, 4'h0, 16'h0, 16'h00b5);
      rchk(MFD_OFF_FLAGS, 32'h5, "flag set");
      xfer(MFD_OFF_DEC1, 1'b0, 32'h0);
      cmp(rd[22:18], 5'h15, "cc fields");
      exe(16'h0, 4'hf, 16'h0, 16'h00aa);
      rchk(MFD_OFF_FLAGS, 32'h5, "flag clear");
      exe(16'h2000, 4'h0, 16'h2, 16'h7e85);
      rchk(MFD_OFF_OPERAND, 32'h1, "loop count");
      rchk(MFD_OFF_PC, 32'h1ff8, "loop back");
      exe(16'h2000, 4'h0, 16'h1, 16'h7e85);
      rchk(MFD_OFF_PC, 32'h2002, "loop exit");
      exe(16'h0, 4'h0, 16'h0, 16'h8800);
      xfer(MFD_OFF_DEC0, 1'b0, 32'h0);
      cmp({23'h0, rd[8:0]}, 32'h84, "trap");
      irq_req_pin <= 1'b1;
      exe(16'h0, 4'h0, 16'h0, 16'h0a3a);
      xfer(MFD_OFF_DEC0, 1'b0, 32'h0);
      cmp(rd[8], 1'b1, "service");
      irq_req_pin <= 1'b0;
   endtask
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      irq_req_pin = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      codes = '{MFD_B_ALW, MFD_B_NE, MFD_B_EQ, MFD_B_GE, MFD_B_LT, MFD_B_GT, MFD_B_LE,
                MFD_B_PL, MFD_B_MI, MFD_B_HI, MFD_B_LOS, MFD_B_VC, MFD_B_VS, MFD_B_HIS,
                MFD_B_LO};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4)
         rchk(a[7:0], 32'h0, "reset");
      t_branch();
      t_double();
      mv(1'b1, 3'h0, 16'h1280, 4'h3, 16'hff80, 4'h9);
      mv(1'b1, 3'h0, 16'h1200, 4'h8, 16'h0000, 4'h4);
      mv(1'b1, 3'h1, 16'h00f0, 4'h1, 16'h00f0, 4'h9);
      mv(1'b0, 3'h0, 16'h8000, 4'h6, 16'h8000, 4'h8);
      t_single();
      t_ctl();
      close_out();
   end
endmodule
